// ---- core/dram_timing_consts.svh ----
/*
  Named settings codes, counter loads and reset values for the DRAM
  wait, acknowledge and row-strobe timing block.
  Assumes it is included by bare name by the design files that need it.
*/
`ifndef DRAM_TIMING_CONSTS_SVH
`define DRAM_TIMING_CONSTS_SVH

// ****************************************************************
// Setting codes
// ****************************************************************
`define STYLE_WAIT      1'h0
`define STYLE_ACK       1'h1
`define MODE_SYNC       1'h0
`define MODE_ASYNC      1'h1
`define BW_NONE         2'h0
`define BW_ONE_T        2'h1
`define BW_HALF_T       2'h2
`define BW_ZERO_T       2'h3
`define AW_NONE         2'h0
`define AW_HALF_T       2'h1
`define AW_DLY_HALF_T   2'h2
`define AW_ONE_T        2'h3
`define RT_SEL_0        2'h0
`define RT_SEL_1        2'h1
`define RT_SEL_2        2'h2
`define RT_SEL_3        2'h3

// ****************************************************************
// Counter loads (edges minus one)
// ****************************************************************
`define REF_LOAD_0      3'h1
`define REF_LOAD_1      3'h2
`define REF_LOAD_2      3'h1
`define REF_LOAD_3      3'h3
`define PRE_LOAD_0      3'h0
`define PRE_LOAD_1      3'h1
`define PRE_LOAD_2      3'h1
`define PRE_LOAD_3      3'h2
`define GRANT_LOAD      3'h0
`define GRANT_TWO_BIT   0

// ****************************************************************
// Acknowledge delays and reset values
// ****************************************************************
`define ACK_NOW         2'h0
`define ACK_ONE         2'h1
`define ACK_TWO         2'h2
`define CFG_RESET       8'h00
`define CNT_ZERO        3'h0

`endif

// ---- core/dram_timing_pkg.sv ----
/*
  Types shared by the DRAM wait, acknowledge and row-strobe timing block.
  Assumes the consts header supplies all numeric codes.
*/
package dram_timing_pkg;

  // Timing settings captured at programming time
  typedef struct packed {
    logic       ack_style_sel;
    logic [1:0] burst_wait_sel;
    logic [1:0] access_wait_sel;
    logic [1:0] row_timing_sel;
    logic       access_mode_sel;
  } cfg_t;

  // Access sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_holdoff,
    st_access,
    st_refresh
  } state_t;

endpackage

// ---- core/dram_edge_counter.sv ----
/*
  Loadable down counter of clock edges, used for refresh low time,
  precharge time and grant settling.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "dram_timing_consts.svh"

module dram_edge_counter (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Load control
  input  wire logic       i_load,
  input  wire logic [2:0] i_load_val,
  // Status
  output logic            o_done
);

  logic [2:0] count_reg;
  logic [2:0] count_next;

  // Next count: load, else count down to zero
  always_comb begin
    count_next = count_reg;
    if (i_load) begin
      count_next = i_load_val;
    end else if (count_reg != `CNT_ZERO) begin
      count_next = count_reg - 3'h1;
    end
  end

  // Count register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= `CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_done = (count_reg == `CNT_ZERO);

endmodule

// ---- core/dram_wait_ack_row_timing.sv ----
/*
  Access framing, row-strobe timing and wait or acknowledge handshake
  of one DRAM controller port, plus refresh row-strobe low time.
  Assumes master inputs are synchronous to i_ref_clk and that a refresh
  requester and a second-port arbiter sit outside.
*/
// Behaviour
// - Burst setting 00 adds no burst waits
// - Burst 01 waits, releases edge after column active
// - Burst 10 waits, releases sooner after column active
// - Burst 11 wait follows column strobes directly
// - Access 00 wait-style: wait only for delayed accesses
// - Access 00 ack-style: ack with row strobe
// - Access 01: handshake one step after row strobe
// - Access 10: delayed-only wait, ack after row strobe
// - Access 11: wait one edge, ack two
// - Refresh row strobe low 2,3,2,4 edges
// - Row strobe 1 or 2 edges after grant change
// - Synchronous and asynchronous first-port access modes
// - Access starts by strobe+select, ends on release
// - Handshake is wait or acknowledge by style bit
// - Mode input 0 sync, 1 async
`timescale 1ns/1ps
`include "dram_timing_consts.svh"

module dram_wait_ack_row_timing (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // Programming
  input  wire logic                i_program_load,
  input  dram_timing_pkg::cfg_t    i_cfg,
  // First-port access
  input  wire logic                i_address_strobe_in,
  input  wire logic                i_chip_select_n,
  input  wire logic                i_access_hold_request_n,
  input  wire logic [3:0]          i_ext_column_strobe_in_n,
  // Arbitration and refresh
  input  wire logic                i_second_port_granted,
  input  wire logic                i_refresh_req,
  // DRAM side and handshake
  output logic                     o_row_strobe_n,
  output logic                     o_handshake_n,
  output logic                     o_refresh_active
);

  import dram_timing_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cfg_t       cfg_reg,        cfg_next;
  state_t     state_reg,      state_next;
  logic       strobe_prev_reg, strobe_prev_next;
  logic       pending_reg,    pending_next;
  logic       delayed_reg,    delayed_next;
  logic [1:0] ack_cnt_reg,    ack_cnt_next;
  logic       acked_reg,      acked_next;
  logic       burst_wait_reg, burst_wait_next;
  logic       ext_column_strobe_in_seen_reg,  ext_column_strobe_in_seen_next;
  logic       grant_prev_reg;
  logic       ras_n_reg,      ras_n_next;
  logic       hs_n_reg,       hs_n_next;
  logic       refresh_reg;
  logic       strobe_lvl;
  logic       strobe_hit;
  logic       ext_column_strobe_in_idle;
  logic       grant_changed;
  logic       grant_two;
  logic       pre_done;
  logic       ref_done;
  logic       grant_done;
  logic       launch_ok;
  logic       pre_load;
  logic       ref_load;
  logic [2:0] pre_val;
  logic [2:0] ref_val;
  logic [1:0] ack_target;
  logic       ack_active;
  logic       wait_active;

  // ****************************************************************
  // Settings capture
  // ****************************************************************
  // load only on programming
  always_comb begin
    cfg_next = i_program_load ? i_cfg : cfg_reg;
  end

  // ****************************************************************
  // Decode of settings and request
  // ****************************************************************
  // mode bit picks strobe sense
  assign strobe_lvl = (cfg_reg.access_mode_sel == `MODE_ASYNC) ? ~i_address_strobe_in
                                                               : i_address_strobe_in;
  // async mode needs a fresh strobe edge
  assign strobe_hit = ~i_chip_select_n & strobe_lvl &
                      ((cfg_reg.access_mode_sel == `MODE_SYNC) | ~strobe_prev_reg);
  assign ext_column_strobe_in_idle  = &i_ext_column_strobe_in_n;

  // counter loads per row timing setting
  always_comb begin
    unique case (cfg_reg.row_timing_sel)
      `RT_SEL_0: begin ref_val = `REF_LOAD_0; pre_val = `PRE_LOAD_0; end
      `RT_SEL_1: begin ref_val = `REF_LOAD_1; pre_val = `PRE_LOAD_1; end
      `RT_SEL_2: begin ref_val = `REF_LOAD_2; pre_val = `PRE_LOAD_2; end
      `RT_SEL_3: begin ref_val = `REF_LOAD_3; pre_val = `PRE_LOAD_3; end
    endcase
  end

  always_comb begin
    unique case (cfg_reg.access_wait_sel)
      `AW_NONE:       ack_target = `ACK_NOW;
      `AW_HALF_T:     ack_target = `ACK_ONE;
      `AW_DLY_HALF_T: ack_target = (cfg_reg.ack_style_sel == `STYLE_WAIT && !delayed_next)
                                   ? `ACK_NOW : `ACK_ONE;
      `AW_ONE_T:      ack_target = (cfg_reg.ack_style_sel == `STYLE_ACK) ? `ACK_TWO : `ACK_ONE;
    endcase
  end

  // grant change holds off one or two edges
  assign grant_changed = (i_second_port_granted != grant_prev_reg);
  assign grant_two     = cfg_reg.row_timing_sel[`GRANT_TWO_BIT];
  assign launch_ok = pre_done & grant_done & ~i_second_port_granted &
                     ~(grant_changed & grant_two);

  // ****************************************************************
  // Timing counters
  // ****************************************************************
  dram_edge_counter u_pre_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_load     (pre_load),
    .i_load_val (pre_val),
    .o_done     (pre_done)
  );

  dram_edge_counter u_ref_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_load     (ref_load),
    .i_load_val (ref_val),
    .o_done     (ref_done)
  );

  dram_edge_counter u_grant_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_load     (grant_changed & grant_two),
    .i_load_val (`GRANT_LOAD),
    .o_done     (grant_done)
  );

  // ****************************************************************
  // Access and refresh sequencer
  // ****************************************************************
  // Next state, row strobe and handshake
  always_comb begin
    state_next       = state_reg;
    strobe_prev_next = strobe_lvl;
    pending_next     = pending_reg;
    delayed_next     = delayed_reg;
    ack_cnt_next     = ack_cnt_reg;
    acked_next       = acked_reg;
    burst_wait_next  = 1'b0;
    ext_column_strobe_in_seen_next   = 1'b0;
    pre_load         = 1'b0;
    ref_load         = 1'b0;
    unique case (state_reg)
      st_idle: begin
        // strobe with select opens an access
        if (strobe_hit) begin
          delayed_next = ~launch_ok;
          state_next   = launch_ok ? st_access : st_holdoff;
        end else if (i_refresh_req && pre_done) begin
          ref_load   = 1'b1;
          state_next = st_refresh;
        end
      end
      st_holdoff: begin
        if (launch_ok) begin
          state_next = st_access;
        end
      end
      st_refresh: begin
        pending_next = pending_reg | strobe_hit;
        if (ref_done) begin
          pre_load     = 1'b1;
          pending_next = 1'b0;
          delayed_next = 1'b1;
          state_next   = (pending_reg | strobe_hit) ? st_holdoff : st_idle;
        end
      end
      st_access: begin
        if (!acked_reg) begin
          ack_cnt_next = ack_cnt_reg + 2'h1;
          acked_next   = (ack_cnt_next >= ack_target);
        end else if (!i_access_hold_request_n && cfg_reg.burst_wait_sel != `BW_NONE) begin
          // burst wait while column strobes idle
          if (ext_column_strobe_in_idle) begin
            burst_wait_next = 1'b1;
          end else if (burst_wait_reg && cfg_reg.burst_wait_sel == `BW_ONE_T) begin
            // hold one more edge after return
            burst_wait_next = ~ext_column_strobe_in_seen_reg;
            ext_column_strobe_in_seen_next  = 1'b1;
          end
          // release at once for half step
        end
        // access ends only on hold release
        if (acked_reg && i_access_hold_request_n) begin
          pre_load        = 1'b1;
          burst_wait_next = 1'b0;
          state_next      = st_idle;
        end
      end
    endcase
    if (state_reg != st_access && state_next == st_access) begin
      ack_cnt_next = 2'h0;
      acked_next   = (ack_target == `ACK_NOW);
    end
    ras_n_next = ~(state_next == st_access || state_next == st_refresh);
    ack_active  = (state_next == st_access) & acked_next & ~burst_wait_next;
    // wait while held off, before ack, during burst waits, or in refresh with an access pending
    // wait kept through the whole holdoff
    wait_active = (state_next == st_holdoff) | ((state_next == st_access) & ~ack_active) |
                  ((state_next == st_refresh) & pending_next);
    hs_n_next   = (cfg_reg.ack_style_sel == `STYLE_ACK) ? ~ack_active : wait_active ? 1'b0 : 1'b1;
  end

  // Registers; inputs taken as synchronous
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg         <= `CFG_RESET;
      state_reg       <= st_idle;
      strobe_prev_reg <= 1'b0;
      pending_reg     <= 1'b0;
      delayed_reg     <= 1'b0;
      ack_cnt_reg     <= 2'h0;
      acked_reg       <= 1'b0;
      burst_wait_reg  <= 1'b0;
      ext_column_strobe_in_seen_reg   <= 1'b0;
      grant_prev_reg  <= 1'b0;
      ras_n_reg       <= 1'b1;
      hs_n_reg        <= 1'b1;
      refresh_reg     <= 1'b0;
    end else begin
      cfg_reg         <= cfg_next;
      state_reg       <= state_next;
      strobe_prev_reg <= strobe_prev_next;
      pending_reg     <= pending_next;
      delayed_reg     <= delayed_next;
      ack_cnt_reg     <= ack_cnt_next;
      acked_reg       <= acked_next;
      burst_wait_reg  <= burst_wait_next;
      ext_column_strobe_in_seen_reg   <= ext_column_strobe_in_seen_next;
      grant_prev_reg  <= i_second_port_granted;
      ras_n_reg       <= ras_n_next;
      hs_n_reg        <= hs_n_next;
      refresh_reg     <= (state_next == st_refresh);
    end
  end

  assign o_row_strobe_n   = ras_n_reg;
  assign o_handshake_n    = hs_n_reg;
  assign o_refresh_active = refresh_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_burst_none;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (cfg_reg.burst_wait_sel == `BW_NONE) |-> !burst_wait_reg;
  endproperty
  a_burst_none: assert property (p_burst_none) else $error("burst wait with setting 00");

  property p_burst_set;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == st_access && acked_reg && !i_access_hold_request_n && ext_column_strobe_in_idle &&
       cfg_reg.burst_wait_sel != `BW_NONE) |=> burst_wait_reg;
  endproperty
  a_burst_set: assert property (p_burst_set) else $error("burst wait not raised");

  property p_burst_fast;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (burst_wait_reg && !ext_column_strobe_in_idle && cfg_reg.burst_wait_sel[1]) |=> !burst_wait_reg;
  endproperty
  a_burst_fast: assert property (p_burst_fast) else $error("fast burst release late");

  property p_ack_with_ras;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($fell(o_row_strobe_n) && state_reg == st_access &&
       cfg_reg.ack_style_sel == `STYLE_ACK && cfg_reg.access_wait_sel == `AW_NONE)
      |-> !o_handshake_n;
  endproperty
  a_ack_with_ras: assert property (p_ack_with_ras) else $error("ack not with row strobe");

  property p_ack_one;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($fell(o_row_strobe_n) && state_reg == st_access &&
       cfg_reg.ack_style_sel == `STYLE_ACK && cfg_reg.access_wait_sel == `AW_HALF_T)
      |-> o_handshake_n ##1 !o_handshake_n;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one edge after row");

  property p_refresh_low;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(o_refresh_active) && cfg_reg.row_timing_sel == `RT_SEL_3 && !i_program_load)
      |-> !o_row_strobe_n[*4] ##1 o_row_strobe_n;
  endproperty
  a_refresh_low: assert property (p_refresh_low) else $error("refresh low not 4 edges");

  property p_precharge;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(o_row_strobe_n) && cfg_reg.row_timing_sel == `RT_SEL_3 && !i_program_load)
      |-> o_row_strobe_n[*3];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge under 3 edges");

  property p_holdoff_wait;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ((state_reg == st_holdoff || (state_reg == st_refresh && pending_reg)) &&
       cfg_reg.ack_style_sel == `STYLE_WAIT) |-> !o_handshake_n;
  endproperty
  a_holdoff_wait: assert property (p_holdoff_wait) else $error("wait off during holdoff");

  property p_hold_keeps;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_reg == st_access && !i_access_hold_request_n) |=> !o_row_strobe_n;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("access ended with hold on");

  property p_cfg_stable;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_program_load |=> $stable(cfg_reg);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("settings changed unprogrammed");

endmodule

// ---- sim/bus_master_model.sv ----
/*
  Behavioural bus master that opens and closes first-port accesses.
  Assumes the controller clock and its row strobe, handshake and refresh
  flag outputs.
*/
`timescale 1ns/1ps

module bus_master_model (
  // Clock
  input  wire logic i_ref_clk,
  // Controller outputs
  input  wire logic i_row_strobe_n,
  input  wire logic i_handshake_n,
  input  wire logic i_refresh_active,
  // Access request lines
  output logic      o_address_strobe_in,
  output logic      o_chip_select_n,
  output logic      o_access_hold_request_n
);
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  // Idle levels
  initial begin
    o_address_strobe_in     = 1'b0;
    o_chip_select_n         = 1'b1;
    o_access_hold_request_n = 1'b1;
  end

  task automatic start(input bit async, input bit ack, output int row_lat,
                       output int hs_lat, output int early);
    @(posedge i_ref_clk);
    o_address_strobe_in     <= !async;
    o_chip_select_n         <= 1'b0;
    o_access_hold_request_n <= 1'b0;
    row_lat = 0;
    early   = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      row_lat++;
      // Refresh row strobe is not the access row strobe
      if ((i_row_strobe_n === 1'b1 || i_refresh_active === 1'b1) &&
          i_handshake_n !== ack) early++;
    end while ((i_row_strobe_n !== 1'b0 || i_refresh_active === 1'b1) && row_lat < 60);
    hs_lat = 0;
    while (i_handshake_n !== !ack && hs_lat < 8) begin
      @(posedge i_ref_clk);
      #1;
      hs_lat++;
    end
  endtask

  task automatic finish(input bit async, output bit ok);
    @(posedge i_ref_clk);
    o_access_hold_request_n <= 1'b1;
    o_chip_select_n         <= 1'b1;
    if (!async) o_address_strobe_in <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    ok = (i_row_strobe_n === 1'b1) && (i_handshake_n === 1'b1);
  endtask

  // Strobe idle level
  task automatic strobe_idle(input bit async);
    @(posedge i_ref_clk);
    o_address_strobe_in <= async;
  endtask
endmodule

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the wait, acknowledge and row-strobe timing.
  Assumes the design package, consts header and the master model.
*/
`timescale 1ns/1ps
`include "dram_timing_consts.svh"

module testbench;
  import dram_timing_pkg::*;
  // ****************************************************************
  // Signals and tables
  // ****************************************************************
  logic       i_ref_clk, i_rst_n, i_program_load, i_second_port_granted, i_refresh_req;
  cfg_t       i_cfg;
  logic [3:0] i_ext_column_strobe_in_n;
  logic       address_strobe, chip_select_n, hold_n, row_strobe_n, handshake_n;
  logic       refresh_active;
  int         failures, n_checks, hi_run, last_hi, rl, hl, er, n, k;
  bit         ok;
  int         pre_t[4]   = '{1, 2, 2, 3};
  int         ref_t[4]   = '{2, 3, 2, 4};
  int         grant_t[4] = '{1, 2, 1, 2};
  int         ack_t[4]   = '{0, 1, 1, 2};
  int         rel_t[4]   = '{1, 2, 1, 1};

  dram_wait_ack_row_timing DUT (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_program_load(i_program_load),
    .i_cfg(i_cfg), .i_address_strobe_in(address_strobe),
    .i_chip_select_n(chip_select_n), .i_access_hold_request_n(hold_n),
    .i_ext_column_strobe_in_n(i_ext_column_strobe_in_n),
    .i_second_port_granted(i_second_port_granted), .i_refresh_req(i_refresh_req),
    .o_row_strobe_n(row_strobe_n), .o_handshake_n(handshake_n),
    .o_refresh_active(refresh_active)
  );

  bus_master_model M (
    .i_ref_clk(i_ref_clk), .i_row_strobe_n(row_strobe_n), .i_handshake_n(handshake_n),
    .i_refresh_active(refresh_active),
    .o_address_strobe_in(address_strobe), .o_chip_select_n(chip_select_n),
    .o_access_hold_request_n(hold_n)
  );

  // 40 MHz clock
  initial i_ref_clk = 1'b0;
  always #12.5 i_ref_clk = ~i_ref_clk;

  // Length of last row strobe high run
  always @(posedge i_ref_clk) begin
    #0.5;
    if (row_strobe_n === 1'b1) hi_run++;
    else begin
      if (hi_run != 0) last_hi = hi_run;
      hi_run = 0;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic cfg_t mk(logic st, logic [1:0] bw, logic [1:0] aw, logic [1:0] rt,
                              logic md);
    return {st, bw, aw, rt, md};
  endfunction

  // Load settings, then scramble the bus
  task automatic prog(input cfg_t c);
    @(posedge i_ref_clk);
    i_program_load <= 1'b1;
    i_cfg          <= c;
    @(posedge i_ref_clk);
    i_program_load <= 1'b0;
    i_cfg          <= cfg_t'(~c);
  endtask

  task automatic refresh(output int len);
    int w;
    len = 0;
    w   = 0;
    @(posedge i_ref_clk) i_refresh_req <= 1'b1;
    while (refresh_active !== 1'b1 && w < 10) begin
      @(posedge i_ref_clk);
      #1;
      w++;
    end
    while (refresh_active === 1'b1 && len < 10) begin
      check(row_strobe_n, 1'b0);
      len++;
      @(posedge i_ref_clk);
      i_refresh_req <= 1'b0;
      #1;
    end
  endtask

  // Hang guard
  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_program_load = 1'b0;
    i_cfg = 8'h00;
    i_second_port_granted = 1'b0;
    i_refresh_req = 1'b0;
    i_ext_column_strobe_in_n = 4'h0;
    failures = 0;
    n_checks = 0;
    hi_run = 0;
    last_hi = 0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    check({row_strobe_n, handshake_n, refresh_active}, 3'h6);
    // Reset settings: sync, wait style, no waits
    M.start(0, 0, rl, hl, er);
    check(rl, 1);
    check(hl, 0);
    M.finish(0, ok);
    check(ok, 1);
    // Access acknowledge delays
    for (k = 0; k < 4; k++) begin
      prog(mk(`STYLE_ACK, `BW_NONE, 2'(k), `RT_SEL_0, `MODE_SYNC));
      M.start(0, 1, rl, hl, er);
      check(rl, 1);
      check(hl, ack_t[k]);
      M.finish(0, ok);
      check(ok, 1);
    end
    prog(mk(`STYLE_WAIT, `BW_NONE, `AW_DLY_HALF_T, `RT_SEL_0, `MODE_SYNC));
    M.start(0, 0, rl, hl, er);
    check(hl, 0);
    M.finish(0, ok);
    // Refresh low time and back-to-back precharge
    for (k = 0; k < 4; k++) begin
      prog(mk(`STYLE_WAIT, `BW_NONE, `AW_NONE, 2'(k), `MODE_SYNC));
      refresh(n);
      check(n, ref_t[k]);
      M.start(0, 0, rl, hl, er);
      M.finish(0, ok);
      M.start(0, 0, rl, hl, er);
      check(last_hi >= pre_t[k], 1);
      check(er, 0);
      M.finish(0, ok);
    end
    // Access during refresh waits for refresh and precharge
    prog(mk(`STYLE_WAIT, `BW_NONE, `AW_NONE, `RT_SEL_3, `MODE_SYNC));
    fork
      refresh(n);
      begin
        repeat (2) @(posedge i_ref_clk);
        M.start(0, 0, rl, hl, er);
      end
    join
    check(rl, 6);
    check(er, 0);
    check(last_hi >= 3, 1);
    M.finish(0, ok);
    // Second-port grant change
    for (k = 0; k < 4; k++) begin
      @(posedge i_ref_clk) i_second_port_granted <= 1'b1;
      prog(mk(`STYLE_ACK, `BW_NONE, `AW_NONE, 2'(k), `MODE_SYNC));
      fork
        M.start(0, 1, rl, hl, er);
        begin
          repeat (4) @(posedge i_ref_clk);
          i_second_port_granted <= 1'b0;
        end
      join
      check(rl, 3 + grant_t[k]);
      check(er, 0);
      M.finish(0, ok);
    end
    // Burst waits on column strobes
    for (k = 0; k < 4; k++) begin
      prog(mk(`STYLE_ACK, 2'(k), `AW_NONE, `RT_SEL_0, `MODE_SYNC));
      M.start(0, 1, rl, hl, er);
      @(posedge i_ref_clk) i_ext_column_strobe_in_n <= 4'hF;
      @(posedge i_ref_clk);
      #1;
      check(handshake_n, k != 0);
      repeat (2) @(posedge i_ref_clk);
      i_ext_column_strobe_in_n <= 4'h0;
      n = 0;
      do begin
        @(posedge i_ref_clk);
        #1;
        n++;
      end while (handshake_n !== 1'b0 && n < 6);
      check(n, rel_t[k]);
      M.finish(0, ok);
    end
    // Asynchronous mode, strobe must toggle per access
    M.strobe_idle(1);
    prog(mk(`STYLE_ACK, `BW_NONE, `AW_NONE, `RT_SEL_0, `MODE_ASYNC));
    M.start(1, 1, rl, hl, er);
    check(rl, 1);
    M.finish(1, ok);
    check(ok, 1);
    M.start(1, 1, rl, hl, er);
    check(rl, 60);
    M.finish(1, ok);
    print_verdict();
  end
endmodule
